/* usrt_consts.vh */
// Register offsets, field positions and reset values of the serial port
`ifndef USRT_CONSTS_VH
`define USRT_CONSTS_VH
`define USRT_IDX_FLAGS 8'h0c
`define USRT_IDX_RXCTL 8'h18
`define USRT_IDX_TXDATA 8'h19
`define USRT_IDX_RXDATA 8'h1a
`define USRT_IDX_IRQEN 8'h8c
`define USRT_IDX_TXCTL 8'h98
`define USRT_IDX_BAUD 8'h99
`define USRT_RST_FLAGS 8'h00
`define USRT_RST_RXCTL 8'h00
`define USRT_RST_IRQEN 8'h00
`define USRT_RST_TXCTL 8'h02
`define USRT_RST_BAUD 8'h00
`define USRT_B_RXAVAIL 5
`define USRT_B_TXFREE 4
`define USRT_B_SERIAL_PORT_ENABLE 7
`define USRT_B_RX9 6
`define USRT_B_SINGLE_RECEIVE_ENABLE 5
`define USRT_B_CONTINUOUS_RECEIVE_ENABLE 4
`define USRT_B_ADDRESS_DETECT_ENABLE 3
`define USRT_B_FRAMING_ERROR 2
`define USRT_B_OVERRUN_ERROR 1
`define USRT_B_RECEIVE_NINTH_BIT_VALUE 0
`define USRT_B_CLOCK_SOURCE_MASTER 7
`define USRT_B_TX9 6
`define USRT_B_TRANSMIT_ENABLE 5
`define USRT_B_SYNC 4
`define USRT_B_HIGH_SPEED_BAUD_SELECT 2
`define USRT_B_TRANSMIT_SHIFT_EMPTY 1
`define USRT_B_TRANSMIT_NINTH_BIT_VALUE 0
`define USRT_HS_DIV 16
`define USRT_LS_DIV 64
`define USRT_SYNC_DIV 4
`endif

/* usrt_top.v */
// Serial port: async transmitter, clocked master receiver, APB registers
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
//
// Operation
// - Async mode when clocked-mode select clear and serial port enable set.
// - Transmit buffer-free flag raises interrupt when transmit interrupt enabled.
// - Ninth-bit enable sends nine bits; ninth value written before data.
// - Setting transmit enable also sets the transmit buffer-free flag.
// - Writing transmit data while enabled starts its serial transmission in async mode only.
// - Clocked reception enabled by single-receive or continuous-receive bit.
// - Clocked reception samples the data pin on serial clock falling edge.
// - Single receive takes one word; continuous until cleared; continuous wins.
// - Last bit moves shift word into FIFO if room, then sets available.
// - Receive interrupt passes only while receive interrupt enable is set.
// - Available flag read-only; cleared when FIFO read and empty.
// - Receive data is a two-entry FIFO, third byte may shift in.
// - FIFO full at last bit sets overrun and discards the shift word.
// - Overrun clears only when software clears continuous receive.
// - While overrun set, no shift-to-FIFO transfers happen.
// - Ninth bit buffered with its byte; FIFO read loads next ninth bit.
// - Clocked master when clocked mode, port enable and master bits set.
`include "usrt_consts.vh"
module usrt_top (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire rx_data_in,
   output reg rx_data_out,
   output reg rx_data_oe,
   input wire tx_clock_in,
   output reg tx_clock_out,
   output reg tx_clock_oe,
   output wire irq
);

   // ****************************************
   // Register bus
   // ****************************************
   reg [7:0] rxctl;
   reg [7:0] txctl;
   reg [7:0] irqen;
   reg [7:0] baud;
   reg txfree;
   reg [8:0] fifo0;
   reg [8:0] fifo1;
   reg [1:0] fcount;
   reg [8:0] txhold;
   reg txpend;
   reg txbusy;
   wire acc = psel & penable;
   wire wr = acc & pwrite;
   wire rd = acc & ~pwrite;
   wire [9:0] widx = paddr[11:2];
   // Word index match; the upper index bits of the bus must be zero
   function hit;
      input [9:0] idx;
      input [7:0] reg_idx;
      hit = (idx == {2'h0, reg_idx});
   endfunction

   // One select per register; the low address bits are ignored on purpose
   wire sel_flags = hit(widx, `USRT_IDX_FLAGS);
   wire sel_rxctl = hit(widx, `USRT_IDX_RXCTL);
   wire sel_txdata = hit(widx, `USRT_IDX_TXDATA);
   wire sel_rxdata = hit(widx, `USRT_IDX_RXDATA);
   wire sel_irqen = hit(widx, `USRT_IDX_IRQEN);
   wire sel_txctl = hit(widx, `USRT_IDX_TXCTL);
   wire sel_baud = hit(widx, `USRT_IDX_BAUD);
   wire mapped = sel_flags | sel_rxctl | sel_txdata | sel_rxdata | sel_irqen | sel_txctl |
      sel_baud;
   wire wr_rxctl = wr & sel_rxctl;
   wire wr_irqen = wr & sel_irqen;
   wire wr_txctl = wr & sel_txctl;
   wire wr_baud = wr & sel_baud;

   // No wait states: every register answers in the access cycle
   assign pready = 1'b1;
   assign pslverr = acc & ~mapped;

   wire sync_mode = txctl[`USRT_B_SYNC];
   wire serial_port_enable = rxctl[`USRT_B_SERIAL_PORT_ENABLE];
   wire async_on = serial_port_enable & ~sync_mode;
   wire master_on = serial_port_enable & sync_mode & txctl[`USRT_B_CLOCK_SOURCE_MASTER];
   wire rxavail = (fcount != 2'h0);
   wire fifo_pop = rd & sel_rxdata & rxavail;
   wire txd_wr = wr & sel_txdata;
   wire [7:0] flags = {2'h0, rxavail, txfree, 4'h0};

   // Level request; it drops by itself once its cause is gone
   // transmit and receive requests gated by enables
   assign irq = (txfree & irqen[`USRT_B_TXFREE]) | (rxavail & irqen[`USRT_B_RXAVAIL]);
   // Read status first, or the next word's ninth bit replaces it
   // status shows ninth bit of FIFO head
   wire [7:0] rxctl_rd = {rxctl[7:1], fifo0[8]};
   wire [7:0] txctl_rd = {txctl[7:2], ~(txbusy | txpend), txctl[0]};

   always @* begin
      prdata = 32'h0;
      if (hit(widx, `USRT_IDX_FLAGS)) prdata = {24'h0, flags};
      if (hit(widx, `USRT_IDX_RXCTL)) prdata = {24'h0, rxctl_rd};
      if (hit(widx, `USRT_IDX_RXDATA)) prdata = {24'h0, fifo0[7:0]};
      if (hit(widx, `USRT_IDX_IRQEN)) prdata = {24'h0, irqen};
      if (hit(widx, `USRT_IDX_TXCTL)) prdata = {24'h0, txctl_rd};
      if (hit(widx, `USRT_IDX_BAUD)) prdata = {24'h0, baud};
   end

   // ****************************************
   // Baud divider
   // ****************************************
   // Runs only with the port enabled, so a new setting starts clean
   reg [7:0] bcnt;
   reg [5:0] pcnt;
   reg tick;
   // prescale 16 with high-speed, else 64; clocked mode 4
   wire [5:0] pre_top = sync_mode ? 6'h03 : (txctl[`USRT_B_HIGH_SPEED_BAUD_SELECT] ? 6'h0f : 6'h3f);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bcnt <= 8'h0;
         pcnt <= 6'h0;
         tick <= 1'b0;
      end else begin
         tick <= 1'b0;
         if (!serial_port_enable) begin
            bcnt <= 8'h0;
            pcnt <= 6'h0;
         end else if (pcnt >= pre_top) begin
            pcnt <= 6'h0;
            if (bcnt >= baud) begin
               bcnt <= 8'h0;
               tick <= 1'b1;
            end else begin
               bcnt <= bcnt + 8'h1;
            end
         end else begin
            pcnt <= pcnt + 6'h1;
         end
      end
   end

   // ****************************************
   // Transmitter
   // ****************************************
   // Start, up to nine data bits and stop fit in one shift word
   reg [10:0] tsh;
   reg [3:0] tleft;
   reg tx_line;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         txctl <= `USRT_RST_TXCTL;
         txfree <= 1'b0;
         txhold <= 9'h0;
         txpend <= 1'b0;
         txbusy <= 1'b0;
         tsh <= 11'h7ff;
         tleft <= 4'h0;
         tx_line <= 1'b1;
      end else begin
         if (wr_txctl) begin
            txctl <= {pwdata[7:4], 1'b0, pwdata[2], 1'b0, pwdata[0]};
            if (pwdata[`USRT_B_TRANSMIT_ENABLE] && !txctl[`USRT_B_TRANSMIT_ENABLE]) txfree <= 1'b1;
            if (!pwdata[`USRT_B_TRANSMIT_ENABLE]) begin
               txpend <= 1'b0;
               txbusy <= 1'b0;
               tx_line <= 1'b1;
            end
         end
         // ninth bit taken at data write
         if (txd_wr && txctl[`USRT_B_TRANSMIT_ENABLE]) begin
            txhold <= {txctl[`USRT_B_TRANSMIT_NINTH_BIT_VALUE], pwdata[7:0]};
            txpend <= 1'b1;
            txfree <= 1'b0;
         end
         // A held byte waits for an idle line; buffer-free rises at load
         if (txpend && !txbusy && !txd_wr && async_on && txctl[`USRT_B_TRANSMIT_ENABLE]) begin
            // start low, LSB first, stop high
            tsh <= {1'b1, txhold, 1'b0};
            tleft <= txctl[`USRT_B_TX9] ? 4'hb : 4'ha;
            txbusy <= 1'b1;
            txpend <= 1'b0;
            txfree <= 1'b1;
         end else if (txbusy && tick) begin
            if (tleft == 4'd1) begin
               txbusy <= 1'b0;
               tx_line <= 1'b1;
            end else begin
               tx_line <= tsh[0];
               tsh <= {1'b1, tsh[10:1]};
            end
            tleft <= tleft - 4'h1;
         end
      end
   end

   // ****************************************
   // Clocked master receiver
   // ****************************************
   reg [2:0] dsync;
   reg [8:0] rsh;
   reg [3:0] rbits;
   reg ck_phase;
   // Three flops on the data pin; a change counts once the last two agree
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) dsync <= 3'h0;
      else dsync <= {dsync[1:0], rx_data_in};
   end
   reg din;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) din <= 1'b0;
      else if (dsync[2] == dsync[1]) din <= dsync[2];
   end

   // ****************************************
   // Clock pin sampler
   // ****************************************
   // Sampling follows the clock as it stands on the pin, so a slow or
   // loaded pin delays the sample instead of letting it race the data
   reg [2:0] csync;
   reg ck_seen;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) csync <= 3'h0;
      else csync <= {csync[1:0], tx_clock_in};
   end
   // Starts at the pin's idle low level, so reset makes no false edge
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) ck_seen <= 1'b0;
      else if (csync[2] == csync[1]) ck_seen <= csync[2];
   end
   // falling edge found once the last two flops agree low
   wire pin_fall = ck_seen & (csync[2] == csync[1]) & ~csync[2];

   // reception enabled by either bit; continuous wins
   wire rx_on = master_on & (rxctl[`USRT_B_SINGLE_RECEIVE_ENABLE] | rxctl[`USRT_B_CONTINUOUS_RECEIVE_ENABLE]);
   wire [3:0] rx_len = rxctl[`USRT_B_RX9] ? 4'h9 : 4'h8;
   wire fall = rx_on & pin_fall;
   wire last = fall & (rbits == rx_len - 4'h1);
   wire [8:0] rword = rxctl[`USRT_B_RX9] ? {din, rsh[8:1]} : {1'b0, din, rsh[8:2]};

   // A word that finds no room is dropped whole, never half written
   // transfer if room; blocked by overrun
   wire push = last & ~rxctl[`USRT_B_OVERRUN_ERROR] & (fcount != 2'h2);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxctl <= `USRT_RST_RXCTL;
         irqen <= `USRT_RST_IRQEN;
         baud <= `USRT_RST_BAUD;
         rsh <= 9'h0;
         rbits <= 4'h0;
         ck_phase <= 1'b0;
         fifo0 <= 9'h0;
         fifo1 <= 9'h0;
         fcount <= 2'h0;
         tx_clock_out <= 1'b0;
      end else begin
         if (wr_irqen) irqen <= pwdata[7:0];
         if (wr_baud) baud <= pwdata[7:0];
         if (wr_rxctl) begin
            rxctl[7:3] <= pwdata[7:3];
            // overrun cleared by clearing continuous receive
            if (!pwdata[`USRT_B_CONTINUOUS_RECEIVE_ENABLE]) rxctl[`USRT_B_OVERRUN_ERROR] <= 1'b0;
         end
         // full FIFO at last bit sets overrun, word lost
         if (last && fcount == 2'h2) rxctl[`USRT_B_OVERRUN_ERROR] <= 1'b1;
         // single receive ends after one word unless continuous
         if (last && !rxctl[`USRT_B_CONTINUOUS_RECEIVE_ENABLE]) rxctl[`USRT_B_SINGLE_RECEIVE_ENABLE] <= 1'b0;
         if (!rx_on) begin
            rbits <= 4'h0;
            ck_phase <= 1'b0;
            tx_clock_out <= 1'b0;
         end else begin
            if (tick) begin
               ck_phase <= ~ck_phase;
               tx_clock_out <= ~ck_phase;
            end
            if (fall) begin
               rsh <= {din, rsh[8:1]};
               rbits <= last ? 4'h0 : rbits + 4'h1;
            end
         end

         // two-entry FIFO; ninth bit travels with byte
         case ({push, fifo_pop})
            2'b10: begin
               if (fcount == 2'h0) fifo0 <= rword;
               else fifo1 <= rword;
               fcount <= fcount + 2'h1;
            end
            2'b01: begin
               fifo0 <= fifo1;
               fcount <= fcount - 2'h1;
            end
            2'b11: begin
               if (fcount == 2'h1) fifo0 <= rword;
               else begin
                  fifo0 <= fifo1;
                  fifo1 <= rword;
               end
            end
            default: begin
               fcount <= fcount;
            end
         endcase
      end
   end

   // ****************************************
   // Pin drive
   // ****************************************
   // Registered enables keep decode glitches off the pins
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_clock_oe <= 1'b0;
         rx_data_out <= 1'b1;
         rx_data_oe <= 1'b0;
      end else begin
         tx_clock_oe <= master_on;
         rx_data_oe <= async_on & txctl[`USRT_B_TRANSMIT_ENABLE];
         rx_data_out <= tx_line;
      end
   end
endmodule

/* usrt_assertions.sv */
// Port checker of the serial port
`timescale 1ns/1ps
module usrt_assertions (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pslverr,
   input wire rx_data_out,
   input wire rx_data_oe,
   input wire tx_clock_out,
   input wire tx_clock_oe,
   input wire irq
);
   reg [7:0] ien;
   reg [7:0] tctl;
   reg [7:0] baud;
   reg serial_port_enable;
   wire wr = psel & penable & pwrite;
   wire mst = tctl[7] & tctl[4] & serial_port_enable;
   wire atx = tctl[5] & ~tctl[4] & serial_port_enable;
   wire [9:0] wi = paddr[11:2];
   wire hit = wi == 10'h00c || wi == 10'h018 || wi == 10'h019 || wi == 10'h01a
      || wi == 10'h08c || wi == 10'h098 || wi == 10'h099;
   // Shadow settings, the checker cannot see the registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ien <= 8'h00;
         tctl <= 8'h02;
         baud <= 8'h00;
         serial_port_enable <= 1'b0;
      end else if (wr) begin
         if (wi == 10'h08c) ien <= pwdata[7:0];
         if (wi == 10'h098) tctl <= pwdata[7:0];
         if (wi == 10'h099) baud <= pwdata[7:0];
         if (wi == 10'h018) serial_port_enable <= pwdata[7];
      end
   end
   // ****************
   // Properties
   // ****************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence txd_write;
      wr && wi == 10'h019 && atx && baud == 8'h00 && tctl[2];
   endsequence
   chk_tx_start: assert property (txd_write |-> ##[1:400] !rx_data_out)
      else $error("transmit write gave no start bit");
   chk_async_drive: assert property (atx [*3] |-> rx_data_oe)
      else $error("async line not driven");
   chk_master_drive: assert property (mst [*3] |-> tx_clock_oe)
      else $error("master clock not driven");
   chk_clock_quiet: assert property (!mst [*3] |-> !tx_clock_oe)
      else $error("clock pin driven outside master mode");
   chk_clock_rate: assert property (mst && $past(baud, 16) == 8'h01 && $fell(tx_clock_out)
      |=> $stable(tx_clock_out) [*7])
      else $error("serial clock half period too short");
   chk_irq_mask: assert property (ien[5:4] == 2'b00 |-> !irq)
      else $error("interrupt while masked");
   chk_tx_irq: assert property ($rose(tctl[5]) && ien[4] |-> ##[0:2] irq)
      else $error("no interrupt after transmit enable");
   chk_unmapped_err: assert property (psel && penable && !hit |-> pslverr && prdata == 0)
      else $error("unmapped access not refused");
endmodule
bind usrt_top usrt_assertions i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pslverr(pslverr), .rx_data_out(rx_data_out), .rx_data_oe(rx_data_oe),
   .tx_clock_out(tx_clock_out), .tx_clock_oe(tx_clock_oe), .irq(irq));

/* usrt_peer.sv */
// Remote serial peer feeding words to the master receiver
`timescale 1ns/1ps
module usrt_peer (
   input wire sclk,
   input wire en,
   input wire [3:0] nbits,
   output reg sdata
);
   logic [8:0] words[$];
   integer cnt = 0;
   initial sdata = 1'b1;
   always @(posedge sclk) begin
      if (en && words.size() > 0) begin
         sdata <= words[0][cnt];
      end else begin
         sdata <= ~sdata;
      end
   end
   always @(negedge sclk) begin
      if (en && words.size() > 0) begin
         cnt = cnt + 1;
         if (cnt == nbits) begin
            cnt = 0;
            void'(words.pop_front());
         end
      end
   end
endmodule

/* usrt_top_tb.sv */
// Self-checking bench of the serial port
`timescale 1ns/1ps
`include "usrt_consts.vh"
module usrt_top_tb;
   localparam [7:0] fl = `USRT_IDX_FLAGS, rc = `USRT_IDX_RXCTL, td = `USRT_IDX_TXDATA;
   localparam [7:0] rx = `USRT_IDX_RXDATA, ie = `USRT_IDX_IRQEN, tc = `USRT_IDX_TXCTL;
   localparam [7:0] bd = `USRT_IDX_BAUD;
   reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, en = 1'b0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h00000000, rd;
   reg [3:0] nb = 4'h8;
   wire [31:0] prdata;
   wire pready, pslverr, rxo, rxoe, sdo, sclk, sclkoe, irq;
   wire rxd = rxoe ? rxo : sdo;
   // Clock pin held low by a pull-down when idle
   wire cpin = sclkoe ? sclk : 1'b0;
   integer n_mismatch = 0, num_checks = 0, i;
   always #4 pclk = ~pclk;
   usrt_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_data_in(rxd), .rx_data_out(rxo), .rx_data_oe(rxoe),
      .tx_clock_in(cpin), .tx_clock_out(sclk), .tx_clock_oe(sclkoe), .irq(irq));
   usrt_peer i_peer (.sclk(cpin), .en(en), .nbits(nb), .sdata(sdo));
   task chk(input string nm, input [31:0] seen, input [31:0] exp);
      num_checks = num_checks + 1;
      if (seen !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task apb(input w, input [7:0] idx, input [7:0] d);
      integer t;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      t = 0;
      do begin
         @(posedge pclk);
         t = t + 1;
      end while (pready !== 1'b1 && t < 50);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task wr(input [7:0] idx, input [7:0] d);
      apb(1'b1, idx, d);
   endtask
   task rdc(input [7:0] idx, input [7:0] m, input [7:0] e);
      apb(1'b0, idx, 8'h00);
      chk($sformatf("reg %h", idx), rd & {24'h0, m}, {24'h0, e & m});
   endtask
   task txf(input [8:0] v, input integer n);
      integer k;
      for (k = 0; k < 300 && rxo !== 1'b0; k = k + 1) @(posedge pclk);
      repeat (8) @(posedge pclk);
      chk("start bit", rxo, 0);
      for (k = 0; k < n; k = k + 1) begin
         repeat (16) @(posedge pclk);
         chk("data bit", rxo, v[k]);
      end
      repeat (16) @(posedge pclk);
      chk("stop bit", rxo, 1);
   endtask
   task waitirq;
      for (i = 0; i < 600 && irq !== 1'b1; i = i + 1) @(posedge pclk);
      chk("irq", irq, 1);
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ****************
   // Tests
   // ****************
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(fl, 8'hff, `USRT_RST_FLAGS);
      rdc(rc, 8'hff, `USRT_RST_RXCTL);
      rdc(tc, 8'hff, `USRT_RST_TXCTL);
      rdc(bd, 8'hff, `USRT_RST_BAUD);
      rdc(ie, 8'hff, `USRT_RST_IRQEN);
      rdc(8'h01, 8'hff, 8'h00);
      $display("test reset done");
      wr(bd, 8'h00);
      wr(tc, 8'h04);
      wr(rc, 8'h80);
      wr(ie, 8'h10);
      wr(tc, 8'h24);
      rdc(fl, 8'h10, 8'h10);
      chk("irq", irq, 1);
      fork
         wr(td, 8'ha5);
         txf(9'h0a5, 8);
      join
      wr(tc, 8'h65);
      fork
         wr(td, 8'h3c);
         txf(9'h13c, 9);
      join
      $display("test transmit done");
      wr(ie, 8'h20);
      wr(bd, 8'h01);
      wr(tc, 8'h90);
      wr(rc, 8'h80);
      i_peer.words = '{9'h05a, 9'h0c3, 9'h0e7};
      en <= 1'b1;
      wr(rc, 8'h90);
      waitirq;
      repeat (400) @(posedge pclk);
      rdc(rc, 8'hff, 8'h92);
      wr(ie, 8'h00);
      chk("irq", irq, 0);
      rdc(rx, 8'hff, 8'h5a);
      rdc(fl, 8'h20, 8'h20);
      rdc(rx, 8'hff, 8'hc3);
      repeat (200) @(posedge pclk);
      rdc(fl, 8'h20, 8'h00);
      wr(rc, 8'h80);
      en <= 1'b0;
      rdc(rc, 8'h02, 8'h00);
      $display("test overrun done");
      nb <= 4'h9;
      wr(ie, 8'h20);
      wr(rc, 8'hc0);
      i_peer.words = '{9'h1c3};
      en <= 1'b1;
      wr(rc, 8'he0);
      waitirq;
      repeat (300) @(posedge pclk);
      rdc(rc, 8'hff, 8'hc1);
      rdc(rx, 8'hff, 8'hc3);
      rdc(fl, 8'h20, 8'h00);
      $display("test single receive done");
      end_of_test;
   end
   initial begin
      #100000;
      n_mismatch = n_mismatch + 1;
      end_of_test;
   end
endmodule
